// File: hw/regbuf_pkg.sv
// Constants shared by the registered buffer and its error log
package regbuf_pkg;
  localparam int WIDE_BITS = 25;
  localparam int NARROW_BITS = 14;
  localparam int LOG_DEPTH = 32;
  // Data positions per pin arrangement, bit n is input n+1
  localparam logic [24:0] MASK_WIDE = 25'h1FFFFB6;
  localparam logic [24:0] MASK_NARROW_A = 25'h0003FB6;
  localparam logic [24:0] MASK_NARROW_B = 25'h0001BBF;
  localparam logic [24:0] DATA_RESET = 25'h0000000;
  localparam logic [13:0] NARROW_RESET = 14'h0000;
  localparam logic [1:0] ERR_HOLD_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    ERR_IDLE = 2'b01,
    ERR_HOLD = 2'b10
  } err_state_t;

  function automatic logic [24:0] data_mask(input logic fanout,
                                            input logic half);
    if (!fanout)
      return MASK_WIDE;
    return half ? MASK_NARROW_B : MASK_NARROW_A;
  endfunction
endpackage

// File: hw/error_log_fifo.sv
// Error log FIFO with registered output stage
`timescale 1ns/100ps
module error_log_fifo
  import regbuf_pkg::*;
#(
  parameter int WIDTH = WIDE_BITS,
  parameter int DEPTH = LOG_DEPTH
)(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // ********************************************************
  // Pointers and count
  // ********************************************************
  // Pop moves a word into the output stage whenever it is free
  assign inReady = (count != FULL_COUNT);
  assign push = inValid && inReady;
  assign pop = (count != '0) && (!outValid || outReady);

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wrPtr <= AW'(wrPtr + 1'b1);
      if (pop)
        rdPtr <= AW'(rdPtr + 1'b1);
      count <= (AW+1)'(count + push - pop);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      outValid <= 1'b0;
      outData <= '0;
    end
    else if (pop)
    begin
      outValid <= 1'b1;
      outData <= mem[rdPtr];
    end
    else if (outReady)
      outValid <= 1'b0;
  end

  a_log_no_overfill: assert property (@(posedge ref_clk) disable iff (!rst_n)
    count == FULL_COUNT |-> !push)
    else $error("log written while full");
  a_log_stall_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    outValid && !outReady |=> outValid && $stable(outData))
    else $error("log output changed while stalled");
endmodule

// File: hw/registered_buffer_parity_check.sv
// Registered address buffer with delayed input parity check
`timescale 1ns/100ps
module registered_buffer_parity_check
  import regbuf_pkg::*;
#(
  parameter int DATA_BITS = WIDE_BITS,
  parameter int PAIR_BITS = NARROW_BITS,
  parameter int LOG_WORDS = LOG_DEPTH
)(
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic [DATA_BITS-1:0] bufferedDataInputs,
  input  wire logic                 primaryChipSelectIn,
  input  wire logic                 secondaryChipSelectIn,
  input  wire logic                 onDieTermIn,
  input  wire logic                 clockEnableIn,
  input  wire logic                 parityBitIn,
  input  wire logic                 halfSelectIn,
  input  wire logic                 fanoutSelectIn,
  input  wire logic                 errLogReady,
  output logic      [DATA_BITS-1:0] registeredOutputs,
  output logic      [PAIR_BITS-1:0] registeredOutputsB,
  output logic                      chipSelectOut,
  output logic                      chipSelectOutB,
  output logic                      onDieTermOut,
  output logic                      onDieTermOutB,
  output logic                      clockEnableOut,
  output logic                      clockEnableOutB,
  output logic                      partialParityOut,
  output logic                      parityErrorOutN,
  output logic                      parityErrorOe,
  output logic                      errLogValid,
  output logic      [DATA_BITS-1:0] errLogData,
  output logic                      errLogSpace
);
  logic [DATA_BITS-1:0] mask;
  logic                 accept;
  logic                 xor0;
  logic                 xor1;
  logic                 acc0;
  logic                 acc1;
  logic [DATA_BITS-1:0] word0;
  logic [DATA_BITS-1:0] word1;
  logic                 chk;
  logic                 chkAcc;
  logic [DATA_BITS-1:0] chkWord;
  logic                 internalLowPowerFlag;
  logic                 errFound;
  err_state_t           errState;
  logic [1:0]           holdCnt;
  logic                 logReady;
  logic                 logPush;

  // ********************************************************
  // Input qualification
  // ********************************************************
  assign mask = data_mask(fanoutSelectIn, halfSelectIn);
  // Both selects high means no command: hold outputs to save power
  assign accept = !(primaryChipSelectIn && secondaryChipSelectIn);

  // ********************************************************
  // Output registers
  // ********************************************************
  // Unused positions follow the mask and stay low
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      registeredOutputs <= DATA_RESET;
      registeredOutputsB <= NARROW_RESET;
      onDieTermOut <= 1'b0;
      onDieTermOutB <= 1'b0;
      clockEnableOut <= 1'b0;
      clockEnableOutB <= 1'b0;
    end
    else if (accept)
    begin
      registeredOutputs <= bufferedDataInputs & mask;
      registeredOutputsB <= fanoutSelectIn ?
        PAIR_BITS'(bufferedDataInputs & mask) : NARROW_RESET;
      onDieTermOut <= onDieTermIn;
      onDieTermOutB <= fanoutSelectIn & onDieTermIn;
      clockEnableOut <= clockEnableIn;
      clockEnableOutB <= fanoutSelectIn & clockEnableIn;
    end
  end

  // Select copies ignore gating so the memory sees every deselect
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      chipSelectOut <= 1'b0;
      chipSelectOutB <= 1'b0;
    end
    else
    begin
      chipSelectOut <= primaryChipSelectIn;
      chipSelectOutB <= fanoutSelectIn & primaryChipSelectIn;
    end
  end

  // ********************************************************
  // Parity pipeline
  // ********************************************************
  // Controls and selects never enter the XOR
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      xor0 <= 1'b0;
      xor1 <= 1'b0;
      acc0 <= 1'b0;
      acc1 <= 1'b0;
      word0 <= DATA_RESET;
      word1 <= DATA_RESET;
    end
    else
    begin
      xor0 <= ^(bufferedDataInputs & mask);
      acc0 <= accept;
      word0 <= bufferedDataInputs & mask;
      xor1 <= xor0;
      acc1 <= acc0;
      word1 <= word0;
    end
  end

  // Parity bit lags one cycle, or two on the second device
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      chk <= 1'b0;
      chkAcc <= 1'b0;
      chkWord <= DATA_RESET;
    end
    else
    begin
      chk <= (halfSelectIn ? xor1 : xor0) ^ parityBitIn;
      chkAcc <= halfSelectIn ? acc1 : acc0;
      chkWord <= halfSelectIn ? word1 : word0;
    end
  end

  assign internalLowPowerFlag = !chkAcc;
  assign errFound = chkAcc && chk;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      partialParityOut <= 1'b0;
    else if (chkAcc)
      partialParityOut <= chk;
  end

  // ********************************************************
  // Error output
  // ********************************************************
  // On the second device the parity input carries the first
  // device's partial parity, so this output is the combined one
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      errState <= ERR_IDLE;
      holdCnt <= 2'h0;
      parityErrorOutN <= 1'b1;
      parityErrorOe <= 1'b0;
    end
    else
    begin
      case (errState)
        ERR_IDLE:
        begin
          if (errFound)
          begin
            errState <= ERR_HOLD;
            holdCnt <= 2'(ERR_HOLD_CYCLES - 2'h1);
            parityErrorOutN <= 1'b0;
            parityErrorOe <= 1'b1;
          end
        end
        ERR_HOLD:
        begin
          if (holdCnt != 2'h0)
            holdCnt <= 2'(holdCnt - 2'h1);
          else if (errFound)
            holdCnt <= 2'(ERR_HOLD_CYCLES - 2'h1);
          else if (!internalLowPowerFlag)
          begin
            errState <= ERR_IDLE;
            parityErrorOutN <= 1'b1;
            parityErrorOe <= 1'b0;
          end
        end
        default:
        begin
          errState <= ERR_IDLE;
          parityErrorOutN <= 1'b1;
          parityErrorOe <= 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // Failing word log
  // ********************************************************
  // A full log drops words; errLogSpace lets the reader see it
  assign logPush = errFound;

  error_log_fifo #(
    .WIDTH (DATA_BITS),
    .DEPTH (LOG_WORDS)
  ) u_log (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .inValid  (logPush),
    .inReady  (logReady),
    .inData   (chkWord),
    .outValid (errLogValid),
    .outReady (errLogReady),
    .outData  (errLogData)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      errLogSpace <= 1'b0;
    else
      errLogSpace <= logReady;
  end

  // ********************************************************
  // Checks
  // ********************************************************
  sequence s_bad_word;
    accept && !halfSelectIn && (^(bufferedDataInputs & mask))
    ##1 !parityBitIn;
  endsequence

  // Second device sees its parity bit two cycles after the data
  sequence s_bad_word_b;
    accept && halfSelectIn && (^(bufferedDataInputs & mask))
    ##2 !parityBitIn;
  endsequence

  sequence s_good_word;
    accept && !halfSelectIn && !(^(bufferedDataInputs & mask))
    ##1 !parityBitIn;
  endsequence

  a_capture_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    accept |=> registeredOutputs == $past(bufferedDataInputs & mask))
    else $error("accepted word not registered");
  a_gate_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !accept |=> $stable(registeredOutputs))
    else $error("outputs moved while deselected");
  a_parity_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_bad_word |=> ##1 partialParityOut)
    else $error("partial parity wrong two cycles after data");
  a_error_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_bad_word |=> ##1 !parityErrorOutN)
    else $error("odd parity did not pull error low");
  a_error_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(parityErrorOutN) |=> !parityErrorOutN)
    else $error("error released before two cycles");
  a_error_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
    internalLowPowerFlag && parityErrorOutN |=> parityErrorOutN)
    else $error("error changed in low power");
  a_reset_outputs: assert property (@(posedge ref_clk)
    !rst_n |=> registeredOutputs == DATA_RESET && !partialParityOut
               && parityErrorOutN && !chipSelectOut)
    else $error("reset did not clear outputs");
  a_unused_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !fanoutSelectIn |=> (registeredOutputs & ~MASK_WIDE) == DATA_RESET)
    else $error("unused positions driven in 1:1 mode");
  a_pair_copies: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fanoutSelectIn |=> registeredOutputsB
                       == PAIR_BITS'(registeredOutputs))
    else $error("B copy differs from A copy");
  a_select_pass: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> chipSelectOut == $past(primaryChipSelectIn))
    else $error("select output not registered");
  a_parity_delay_b: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_bad_word_b |=> ##1 partialParityOut)
    else $error("partial parity wrong on second device");
  a_error_low_b: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_bad_word_b |=> ##1 !parityErrorOutN)
    else $error("second device did not flag odd parity");
  a_good_clean: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_good_word |=> ##1 !partialParityOut)
    else $error("even parity gave partial parity high");
  a_ppo_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !chkAcc |=> $stable(partialParityOut))
    else $error("partial parity moved for deselected word");
  a_odt_pass: assert property (@(posedge ref_clk) disable iff (!rst_n)
    accept |=> onDieTermOut == $past(onDieTermIn))
    else $error("termination control not registered");
  a_copy_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fanoutSelectIn |=> chipSelectOutB == chipSelectOut)
    else $error("select copies differ in 1:2 mode");
endmodule

// File: bench/ctrl_model.sv
// Controller model: data word now, its parity one or two cycles later
`timescale 1ns/100ps
module ctrl_model
  import regbuf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        halfSelectIn,
  input  wire logic        fanoutSelectIn,
  input  wire logic [24:0] wordIn,
  input  wire logic        flipParity,
  output logic      [24:0] dataOut,
  output logic             parityOut
);
  // ****************************************
  // Parity pipeline
  // ****************************************
  logic [24:0] mask;
  logic        pend1;
  logic        pend2;

  assign dataOut = wordIn;
  assign mask = !fanoutSelectIn ? MASK_WIDE :
                halfSelectIn ? MASK_NARROW_B : MASK_NARROW_A;

  // Sample on the rising edge, where the word is already stable
  always @(posedge ref_clk)
  begin
    pend1 <= ^(wordIn & mask) ^ flipParity;
    pend2 <= pend1;
  end

  // Second device of a pair sees parity one cycle later still
  always @(negedge ref_clk)
  begin
    parityOut <= halfSelectIn ? pend2 : pend1;
  end
endmodule

// File: bench/registered_buffer_parity_check_tb.sv
// Testbench for the registered buffer with parity check
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module registered_buffer_parity_check_tb
  import regbuf_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        ref_clk = 1'b0;
  logic        rst_n;
  logic [24:0] word;
  logic        flip, pcs, scs, odt, cke, half, fan, logReady;
  wire  [24:0] dataIn;
  wire         parityIn;
  logic [24:0] regOut, logData, mask;
  logic [13:0] regOutB;
  logic        csOut, csOutB, odtOut, odtOutB, ckeOut, ckeOutB;
  logic        partial_parity_out, errN, errOe, logValid, logSpace;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          seen;
  int          dly;

  ctrl_model partner (.ref_clk(ref_clk), .halfSelectIn(half),
    .fanoutSelectIn(fan), .wordIn(word), .flipParity(flip),
    .dataOut(dataIn), .parityOut(parityIn));

  registered_buffer_parity_check dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .bufferedDataInputs(dataIn), .primaryChipSelectIn(pcs),
    .secondaryChipSelectIn(scs), .onDieTermIn(odt),
    .clockEnableIn(cke), .parityBitIn(parityIn), .halfSelectIn(half),
    .fanoutSelectIn(fan), .errLogReady(logReady),
    .registeredOutputs(regOut), .registeredOutputsB(regOutB),
    .chipSelectOut(csOut), .chipSelectOutB(csOutB),
    .onDieTermOut(odtOut), .onDieTermOutB(odtOutB),
    .clockEnableOut(ckeOut), .clockEnableOutB(ckeOutB),
    .partialParityOut(partial_parity_out), .parityErrorOutN(errN),
    .parityErrorOe(errOe), .errLogValid(logValid),
    .errLogData(logData), .errLogSpace(logSpace));

  always #5 ref_clk = ~ref_clk;

  // Whole run is under seven hundred cycles; this only cuts a hang
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      endSim();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic endSim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One word per clock, inputs change on the falling edge
  task automatic step(input logic [24:0] w, input logic f,
                      input logic p, input logic s);
    word = w;
    flip = f;
    pcs = p;
    scs = s;
    @(negedge ref_clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    {flip, pcs, scs, odt, cke, logReady, half, fan} = 8'h00;
    word = 25'h0000000;
    for (int md = 0; md < 3; md++)
    begin
      rst_n = 1'b0;
      fan = (md != 0);
      half = (md == 2);
      dly = half ? 3 : 2;
      mask = !fan ? MASK_WIDE : half ? MASK_NARROW_B : MASK_NARROW_A;
      odt = 1'b1;
      cke = 1'b1;
      repeat (8) step(25'h1FFFFFF, 1'b1, 1'b1, 1'b1);
      `CHK("regOut", 25'h0000000, regOut)
      `CHK("csOut", 1'b0, csOut)
      `CHK("ppo", 1'b0, partial_parity_out)
      `CHK("errN", 1'b1, errN)
      `CHK("errOe", 1'b0, errOe)
      rst_n = 1'b1;
      step(25'h1FFFFFF, 1'b0, 1'b1, 1'b0);
      `CHK("regOut", mask, regOut)
      `CHK("regOutB", fan ? mask[13:0] : 14'h0000, regOutB)
      `CHK("csOutB", fan, csOutB)
      `CHK("ckeOutB", fan, ckeOutB)
      `CHK("odtOut", 1'b1, odtOut)
      `CHK("ckeOut", 1'b1, ckeOut)
      `CHK("odtOutB", fan, odtOutB)
      odt = 1'b0;
      cke = 1'b0;
      step(25'h0000000, 1'b1, 1'b1, 1'b1);
      `CHK("regOut", mask, regOut)
      `CHK("odtOut", 1'b1, odtOut)
      `CHK("ckeOut", 1'b1, ckeOut)
      `CHK("csOut", 1'b1, csOut)
      step(25'h0000000, 1'b0, 1'b0, 1'b0);
      `CHK("regOut", 25'h0000000, regOut)
      `CHK("ckeOut", 1'b0, ckeOut)
      `CHK("csOut", 1'b0, csOut)
      if (half)
        step(25'h0000000, 1'b0, 1'b0, 1'b0);
      `CHK("errN", 1'b1, errN)
      step(25'h0000000, 1'b0, 1'b0, 1'b0);
      `CHK("ppo", 1'b0, partial_parity_out)
      `CHK("errN", 1'b1, errN)
      // Single bad word: error two cycles, then clear
      step(25'h0000002, 1'b1, 1'b0, 1'b0);
      for (int i = 1; i <= dly + 2; i++)
      begin
        step(25'h0000000, 1'b0, 1'b0, 1'b0);
        `CHK("ppo", 1'(i == dly), partial_parity_out)
        `CHK("errN", 1'(i < dly || i > dly + 1), errN)
        `CHK("errOe", 1'(i >= dly && i <= dly + 1), errOe)
      end
      `CHK("logValid", 1'b1, logValid)
      `CHK("logData", 25'h0000002, logData)
      logReady = 1'b1;
      step(25'h0000000, 1'b0, 1'b0, 1'b0);
      logReady = 1'b0;
      `CHK("logValid", 1'b0, logValid)
      // Reset cuts a held error short
      step(25'h0000002, 1'b1, 1'b0, 1'b0);
      repeat (dly) step(25'h0000000, 1'b0, 1'b0, 1'b0);
      rst_n = 1'b0;
      step(25'h0000000, 1'b0, 1'b0, 1'b0);
      `CHK("errN", 1'b1, errN)
      rst_n = 1'b1;
      repeat (2) step(25'h0000000, 1'b0, 1'b0, 1'b0);
      // Spaced errors overfill the log, which drops the excess; reader stalls
      repeat (40)
      begin
        step(25'h0000002, 1'b1, 1'b0, 1'b0);
        repeat (3) step(25'h0000000, 1'b0, 1'b0, 1'b0);
      end
      `CHK("logSpace", 1'b0, logSpace)
      logReady = 1'b1;
      seen = 0;
      repeat (45)
      begin
        if (logValid === 1'b1)
          seen++;
        step(25'h0000000, 1'b0, 1'b0, 1'b0);
      end
      logReady = 1'b0;
      `CHK("logCount", LOG_DEPTH + 1, seen)
      `CHK("logValid", 1'b0, logValid)
      `CHK("logSpace", 1'b1, logSpace)
    end
    endSim();
  end
endmodule
